// ==== include/lvdcfg_defines.svh ====
// Offsets, field positions, reset values and masks of the LVDS lane configuration block
//
// Notes on behaviour
// - Channel B fourth lane: layout 0 carries colour MSB pairs, 1 carries LSB pairs.
// - Layout 1 with wide colour off drops two LSBs per colour, giving 18 bpp.
// - Exchange bit 0 sends odd pixels to A, even to B; 1 exchanges them.
// - In two-stream mode the exchange bit crosses input stream A to output B.
// - Channel A reversal swaps lane 0 with lane 3, lane 1 with clock.
// - Channel B reversal applies the same lane swap to channel B.
// - Termination select per channel: 0 is 100 ohm, 1 is 200 ohm, reset 1.
// - Common level trim per channel: 00 none, 01 down 3%, 10 up 3%, 11 up 6%.
// - Swing select per channel is two bits, reset 01, driving output amplitude.
// - Channel B colour settings apply only in two-stream mode with both outputs on.
// - Channel B wide colour off forces 18 bpp and disables its fourth lane.
`ifndef LVDCFG_DEFINES_SVH
`define LVDCFG_DEFINES_SVH

`define LVDCFG_ADR_W          10
`define LVDCFG_IDX_CHAN_MODE  8'h10
`define LVDCFG_IDX_LINK       8'h18
`define LVDCFG_IDX_LEVEL      8'h19
`define LVDCFG_IDX_ROUTE      8'h1A
`define LVDCFG_IDX_TRIM       8'h1B
`define LVDCFG_IDX_STATUS     8'h1C

`define LVDCFG_RST_CHAN_MODE  8'h00
`define LVDCFG_RST_LINK       8'h10
`define LVDCFG_RST_LEVEL      8'h05
`define LVDCFG_RST_ROUTE      8'h03
`define LVDCFG_RST_TRIM       8'h00

`define LVDCFG_MSK_CHAN_MODE  8'h60
`define LVDCFG_MSK_LINK       8'h1F
`define LVDCFG_MSK_LEVEL      8'h5F
`define LVDCFG_MSK_ROUTE      8'h73
`define LVDCFG_MSK_TRIM       8'h33

`define LVDCFG_MODE_LSB       5
`define LVDCFG_SINGLE_BIT     4
`define LVDCFG_A_WIDE_BIT     3
`define LVDCFG_B_WIDE_BIT     2
`define LVDCFG_A_LAYOUT_BIT   1
`define LVDCFG_B_LAYOUT_BIT   0
`define LVDCFG_A_LEVEL_BIT    6
`define LVDCFG_B_LEVEL_BIT    4
`define LVDCFG_A_SWING_LSB    2
`define LVDCFG_B_SWING_LSB    0
`define LVDCFG_SWAP_BIT       6
`define LVDCFG_A_REV_BIT      5
`define LVDCFG_B_REV_BIT      4
`define LVDCFG_A_TERM_BIT     1
`define LVDCFG_B_TERM_BIT     0
`define LVDCFG_A_TRIM_LSB     4
`define LVDCFG_B_TRIM_LSB     0

`define LVDCFG_CLK_PATTERN    7'h63

`endif

// ==== include/lvdcfg_pkg.sv ====
// Types shared by the LVDS lane configuration block
package lvdcfg_pkg;

  typedef enum logic [1:0] {
    LVDCFG_MODE_PAIR_A     = 2'h0,
    LVDCFG_MODE_PAIR_B     = 2'h1,
    LVDCFG_MODE_TWO_STREAM = 2'h2,
    LVDCFG_MODE_RSVD       = 2'h3
  } lvdcfg_chan_mode_t;

  typedef logic [6:0]  lvdcfg_word_t;
  typedef logic [23:0] lvdcfg_rgb_t;

  // Index 0 is channel A, index 1 is channel B
  typedef struct packed {
    lvdcfg_chan_mode_t mode;
    logic              single;
    logic [1:0]        wide;
    logic [1:0]        layout;
    logic              swap;
    logic [1:0]        rev;
  } lvdcfg_cfg_t;

endpackage : lvdcfg_pkg

// ==== hdl/lvdcfg_lane_map.sv ====
// Colour packing and pin order of one LVDS output channel
`timescale 1ns/1ps
`include "lvdcfg_defines.svh"

module lvdcfg_lane_map
  import lvdcfg_pkg::*;
(
  input  lvdcfg_rgb_t rgb,
  input  logic        sync_h,
  input  logic        sync_v,
  input  logic        data_en,
  input  logic        chan_on,
  input  logic        wide,
  input  logic        layout,
  input  logic        rev,
  output logic [34:0] lanes,
  output logic [4:0]  lane_en
);

  logic [5:0]   r6;
  logic [5:0]   g6;
  logic [5:0]   b6;
  logic [5:0]   extra;
  lvdcfg_word_t w [0:4];
  logic [4:0]   en;

  always_comb begin
    // Lane 3 in MSB layout takes the top pair, the core lanes the rest
    if (wide && !layout) begin
      r6    = rgb[21:16];
      g6    = rgb[13:8];
      b6    = rgb[5:0];
      extra = {rgb[7:6], rgb[15:14], rgb[23:22]};
    end else begin
      r6    = rgb[23:18];
      g6    = rgb[15:10];
      b6    = rgb[7:2];
      extra = {rgb[1:0], rgb[9:8], rgb[17:16]};
    end
    w[0] = {g6[0], r6};
    w[1] = {b6[1:0], g6[5:1]};
    w[2] = {data_en, sync_v, sync_h, b6[5:2]};
    w[3] = wide ? {1'b0, extra} : 7'h00;
    w[4] = `LVDCFG_CLK_PATTERN;
    en   = {1'b1, wide, 3'h7};
    if (!chan_on) begin
      for (int i = 0; i < 5; i++) begin
        w[i] = 7'h00;
      end
      en = 5'h00;
    end
    // Reversed order swaps lane 0 with 3 and lane 1 with the clock pair
    if (rev) begin
      lanes   = {w[1], w[0], w[2], w[4], w[3]};
      lane_en = {en[1], en[0], en[2], en[4], en[3]};
    end else begin
      lanes   = {w[4], w[3], w[2], w[1], w[0]};
      lane_en = en;
    end
  end

endmodule : lvdcfg_lane_map

// ==== hdl/lvdcfg_top.sv ====
// Register file, clock crossing and pixel routing of the LVDS output lanes
`timescale 1ns/1ps
`include "lvdcfg_defines.svh"

module lvdcfg_top
  import lvdcfg_pkg::*;
(
  input  logic                    CLK_SYS,
  input  logic                    RST_N,
  input  logic                    CYC_I,
  input  logic                    STB_I,
  input  logic                    WE_I,
  input  logic [`LVDCFG_ADR_W-1:0] ADR_I,
  input  logic [3:0]              SEL_I,
  input  logic [31:0]             DAT_I,
  output logic [31:0]             DAT_O,
  output logic                    ACK_O,
  input  logic                    LINK_CLK,
  input  logic                    PIX_VALID,
  input  lvdcfg_rgb_t             PIX_A_RGB,
  input  lvdcfg_rgb_t             PIX_B_RGB,
  input  logic                    PIX_HS,
  input  logic                    PIX_VS,
  input  logic                    PIX_DE,
  output lvdcfg_word_t            CHAN_A_LANE0,
  output lvdcfg_word_t            CHAN_A_LANE1,
  output lvdcfg_word_t            CHAN_A_LANE2,
  output lvdcfg_word_t            CHAN_A_FOURTH_LANE,
  output lvdcfg_word_t            CHAN_A_CLK_LANE,
  output logic [4:0]              CHAN_A_LANE_EN,
  output lvdcfg_word_t            CHAN_B_LANE0,
  output lvdcfg_word_t            CHAN_B_LANE1,
  output lvdcfg_word_t            CHAN_B_LANE2,
  output lvdcfg_word_t            CHAN_B_FOURTH_LANE,
  output lvdcfg_word_t            CHAN_B_CLK_LANE,
  output logic [4:0]              CHAN_B_LANE_EN,
  output logic                    CHAN_A_TERMINATION_SELECT,
  output logic                    CHAN_B_TERMINATION_SELECT,
  output logic                    CHAN_A_COMMON_LEVEL_SELECT,
  output logic                    CHAN_B_COMMON_LEVEL_SELECT,
  output logic [1:0]              CHAN_A_COMMON_LEVEL_TRIM,
  output logic [1:0]              CHAN_B_COMMON_LEVEL_TRIM,
  output logic [1:0]              CHAN_A_SWING_SELECT,
  output logic [1:0]              CHAN_B_SWING_SELECT
);

  // ----------------------------------------------------------------
  // Register table
  // ----------------------------------------------------------------
  localparam int NREG = 5;
  localparam logic [7:0] REG_IDX [0:NREG-1] = '{
    `LVDCFG_IDX_CHAN_MODE, `LVDCFG_IDX_LINK, `LVDCFG_IDX_LEVEL,
    `LVDCFG_IDX_ROUTE, `LVDCFG_IDX_TRIM};
  localparam logic [7:0] REG_RST [0:NREG-1] = '{
    `LVDCFG_RST_CHAN_MODE, `LVDCFG_RST_LINK, `LVDCFG_RST_LEVEL,
    `LVDCFG_RST_ROUTE, `LVDCFG_RST_TRIM};
  localparam logic [7:0] REG_MSK [0:NREG-1] = '{
    `LVDCFG_MSK_CHAN_MODE, `LVDCFG_MSK_LINK, `LVDCFG_MSK_LEVEL,
    `LVDCFG_MSK_ROUTE, `LVDCFG_MSK_TRIM};
  localparam int CFG_SETTLE_MAX = 24;

  function automatic lvdcfg_cfg_t pack_cfg(input logic [7:0] m,
                                           input logic [7:0] k,
                                           input logic [7:0] r);
    lvdcfg_cfg_t c;
    c.mode   = lvdcfg_chan_mode_t'(m[`LVDCFG_MODE_LSB +: 2]);
    c.single = k[`LVDCFG_SINGLE_BIT];
    c.wide   = {k[`LVDCFG_B_WIDE_BIT], k[`LVDCFG_A_WIDE_BIT]};
    c.layout = {k[`LVDCFG_B_LAYOUT_BIT], k[`LVDCFG_A_LAYOUT_BIT]};
    c.swap   = r[`LVDCFG_SWAP_BIT];
    c.rev    = {r[`LVDCFG_B_REV_BIT], r[`LVDCFG_A_REV_BIT]};
    return c;
  endfunction : pack_cfg

  localparam lvdcfg_cfg_t CFG_RST =
    pack_cfg(`LVDCFG_RST_CHAN_MODE, `LVDCFG_RST_LINK, `LVDCFG_RST_ROUTE);

  logic [7:0]  cfg_reg [0:NREG-1];
  logic [7:0]  idx;
  logic        req;
  logic        wr;
  logic [7:0]  rd_byte;
  logic        pending;
  logic        req_tgl;
  logic        ack_meta;
  logic        ack_sync;
  logic [1:0]  stat_meta;
  logic [1:0]  stat_sync;
  lvdcfg_cfg_t cfg_bus;

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // Accesses wait while a configuration word is still crossing
  assign idx = ADR_I[`LVDCFG_ADR_W-1:2];
  assign req = CYC_I && STB_I && !ACK_O && !pending;
  assign wr  = req && WE_I && SEL_I[0];

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ACK_O <= 1'b0;
    end else begin
      ACK_O <= req;
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    for (int i = 0; i < NREG; i++) begin
      if (idx == REG_IDX[i]) begin
        rd_byte = cfg_reg[i];
      end
    end
    if (idx == `LVDCFG_IDX_STATUS) begin
      rd_byte = {5'h00, stat_sync, pending};
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      DAT_O <= 32'h0000_0000;
    end else if (req && !WE_I) begin
      DAT_O <= {24'h00_0000, rd_byte};
    end
  end

  for (genvar i = 0; i < NREG; i++) begin : g_reg
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
        cfg_reg[i] <= REG_RST[i];
      end else if (wr && idx == REG_IDX[i]) begin
        cfg_reg[i] <= DAT_I[7:0] & REG_MSK[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Analog controls
  // ----------------------------------------------------------------
  assign CHAN_A_TERMINATION_SELECT  = cfg_reg[3][`LVDCFG_A_TERM_BIT];
  assign CHAN_B_TERMINATION_SELECT  = cfg_reg[3][`LVDCFG_B_TERM_BIT];
  assign CHAN_A_COMMON_LEVEL_SELECT = cfg_reg[2][`LVDCFG_A_LEVEL_BIT];
  assign CHAN_B_COMMON_LEVEL_SELECT = cfg_reg[2][`LVDCFG_B_LEVEL_BIT];
  assign CHAN_A_COMMON_LEVEL_TRIM   = cfg_reg[4][`LVDCFG_A_TRIM_LSB +: 2];
  assign CHAN_B_COMMON_LEVEL_TRIM   = cfg_reg[4][`LVDCFG_B_TRIM_LSB +: 2];
  assign CHAN_A_SWING_SELECT        = cfg_reg[2][`LVDCFG_A_SWING_LSB +: 2];
  assign CHAN_B_SWING_SELECT        = cfg_reg[2][`LVDCFG_B_SWING_LSB +: 2];

  // ----------------------------------------------------------------
  // Configuration handshake, system side
  // ----------------------------------------------------------------
  assign cfg_bus = pack_cfg(cfg_reg[0], cfg_reg[1], cfg_reg[3]);

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      req_tgl <= 1'b0;
    end else if (wr) begin
      req_tgl <= ~req_tgl;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      pending <= 1'b0;
    end else if (wr) begin
      pending <= 1'b1;
    end else if (ack_sync == req_tgl) begin
      pending <= 1'b0;
    end
  end

  logic l_seen;
  logic l_two_stream;
  logic l_chan_b_on;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ack_meta  <= 1'b0;
      ack_sync  <= 1'b0;
      stat_meta <= 2'h0;
      stat_sync <= 2'h0;
    end else begin
      ack_meta  <= l_seen;
      ack_sync  <= ack_meta;
      stat_meta <= {l_chan_b_on, l_two_stream};
      stat_sync <= stat_meta;
    end
  end

  // ----------------------------------------------------------------
  // Link side reset and configuration capture
  // ----------------------------------------------------------------
  logic        lrst_meta;
  logic        lrst_n;
  logic        lreq_meta;
  logic        lreq_sync;
  lvdcfg_cfg_t l_cfg;

  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lrst_meta <= 1'b0;
      lrst_n    <= 1'b0;
    end else begin
      lrst_meta <= 1'b1;
      lrst_n    <= lrst_meta;
    end
  end

  always_ff @(posedge LINK_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      lreq_meta <= 1'b0;
      lreq_sync <= 1'b0;
    end else begin
      lreq_meta <= req_tgl;
      lreq_sync <= lreq_meta;
    end
  end

  // The bundle is stable here: writes stall until this capture is acknowledged
  always_ff @(posedge LINK_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      l_cfg  <= CFG_RST;
      l_seen <= 1'b0;
    end else if (lreq_sync != l_seen) begin
      l_cfg  <= cfg_bus;
      l_seen <= lreq_sync;
    end
  end

  // ----------------------------------------------------------------
  // Mode decode and pixel routing
  // ----------------------------------------------------------------
  logic        two_stream;
  logic [1:0]  chan_on;
  logic [1:0]  wide_eff;
  logic [1:0]  layout_eff;
  lvdcfg_rgb_t l_rgb [0:1];
  logic        l_hs;
  logic        l_vs;
  logic        l_de;

  assign two_stream    = !l_cfg.single && l_cfg.mode == LVDCFG_MODE_TWO_STREAM;
  assign chan_on       = {!l_cfg.single, 1'b1};
  assign wide_eff[0]   = l_cfg.wide[0];
  assign layout_eff[0] = l_cfg.layout[0];
  assign wide_eff[1]   = two_stream ? l_cfg.wide[1] : l_cfg.wide[0];
  assign layout_eff[1] = two_stream ? l_cfg.layout[1] : l_cfg.layout[0];

  always_ff @(posedge LINK_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      l_two_stream <= 1'b0;
      l_chan_b_on  <= 1'b0;
    end else begin
      l_two_stream <= two_stream;
      l_chan_b_on  <= chan_on[1];
    end
  end

  // Odd/even pixels and separate streams share one exchange crossbar
  always_ff @(posedge LINK_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      l_rgb[0] <= 24'h00_0000;
      l_rgb[1] <= 24'h00_0000;
    end else if (!PIX_VALID) begin
      l_rgb[0] <= 24'h00_0000;
      l_rgb[1] <= 24'h00_0000;
    end else begin
      l_rgb[0] <= l_cfg.swap ? PIX_B_RGB : PIX_A_RGB;
      l_rgb[1] <= l_cfg.swap ? PIX_A_RGB : PIX_B_RGB;
    end
  end

  always_ff @(posedge LINK_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      l_hs <= 1'b0;
      l_vs <= 1'b0;
      l_de <= 1'b0;
    end else begin
      l_hs <= PIX_HS;
      l_vs <= PIX_VS;
      l_de <= PIX_DE;
    end
  end

  // ----------------------------------------------------------------
  // Lane packing per channel
  // ----------------------------------------------------------------
  logic [34:0] lanes [0:1];
  logic [34:0] lane_q [0:1];
  logic [4:0]  en [0:1];
  logic [4:0]  en_q [0:1];

  for (genvar c = 0; c < 2; c++) begin : g_chan
    lvdcfg_lane_map u_map (
      .rgb     (l_rgb[c]),
      .sync_h  (l_hs),
      .sync_v  (l_vs),
      .data_en (l_de),
      .chan_on (chan_on[c]),
      .wide    (wide_eff[c]),
      .layout  (layout_eff[c]),
      .rev     (l_cfg.rev[c]),
      .lanes   (lanes[c]),
      .lane_en (en[c])
    );

    always_ff @(posedge LINK_CLK or negedge lrst_n) begin
      if (!lrst_n) begin
        lane_q[c] <= 35'h0;
        en_q[c]   <= 5'h00;
      end else begin
        lane_q[c] <= lanes[c];
        en_q[c]   <= en[c];
      end
    end
  end

  assign CHAN_A_LANE0       = lane_q[0][6:0];
  assign CHAN_A_LANE1       = lane_q[0][13:7];
  assign CHAN_A_LANE2       = lane_q[0][20:14];
  assign CHAN_A_FOURTH_LANE = lane_q[0][27:21];
  assign CHAN_A_CLK_LANE    = lane_q[0][34:28];
  assign CHAN_A_LANE_EN     = en_q[0];
  assign CHAN_B_LANE0       = lane_q[1][6:0];
  assign CHAN_B_LANE1       = lane_q[1][13:7];
  assign CHAN_B_LANE2       = lane_q[1][20:14];
  assign CHAN_B_FOURTH_LANE = lane_q[1][27:21];
  assign CHAN_B_CLK_LANE    = lane_q[1][34:28];
  assign CHAN_B_LANE_EN     = en_q[1];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_wr_at(logic [7:0] i);
    wr && idx == i;
  endsequence

  sequence s_b_plain;
    chan_on[1] && !l_cfg.rev[1] && wide_eff[1];
  endsequence

  logic [5:0] b_lsb;
  logic [5:0] b_msb;
  assign b_lsb = {l_rgb[1][1:0], l_rgb[1][9:8], l_rgb[1][17:16]};
  assign b_msb = {l_rgb[1][7:6], l_rgb[1][15:14], l_rgb[1][23:22]};

  a_ack_pulse: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    ACK_O |=> !ACK_O) else $error("ack held longer than one cycle");

  a_term_follow: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    s_wr_at(`LVDCFG_IDX_ROUTE) |=> CHAN_A_TERMINATION_SELECT == $past(DAT_I[1]))
    else $error("termination select did not follow write");

  a_trim_follow: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    s_wr_at(`LVDCFG_IDX_TRIM) |=> CHAN_B_COMMON_LEVEL_TRIM == $past(DAT_I[1:0]))
    else $error("common level trim did not follow write");

  a_swing_reset: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    $rose(RST_N) |-> CHAN_A_SWING_SELECT == 2'h1 && CHAN_B_SWING_SELECT == 2'h1
      && CHAN_A_TERMINATION_SELECT && CHAN_B_TERMINATION_SELECT)
    else $error("analog defaults wrong after reset");

  a_cfg_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !wr |=> $stable({cfg_reg[0], cfg_reg[1], cfg_reg[2], cfg_reg[3], cfg_reg[4]}))
    else $error("configuration changed without a write");

  a_cfg_settle: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    $rose(pending) |-> ##[1:CFG_SETTLE_MAX] !pending)
    else $error("configuration crossing not acknowledged");

  a_odd_route: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
    PIX_VALID && !l_cfg.swap |=> l_rgb[0] == $past(PIX_A_RGB) && l_rgb[1] == $past(PIX_B_RGB))
    else $error("odd pixel not routed to channel A");

  a_stream_swap: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
    PIX_VALID && two_stream && l_cfg.swap |=> l_rgb[1] == $past(PIX_A_RGB))
    else $error("stream A not crossed to channel B");

  a_rev_a_clk: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
    l_cfg.rev[0] |=> CHAN_A_LANE1 == `LVDCFG_CLK_PATTERN && CHAN_A_LANE_EN[1])
    else $error("channel A clock not on lane 1 when reversed");

  a_rev_b_clk: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
    chan_on[1] |=> (($past(l_cfg.rev[1]) ? CHAN_B_LANE1 : CHAN_B_CLK_LANE)
      == `LVDCFG_CLK_PATTERN))
    else $error("channel B clock pair misplaced");

  a_lsb_lane: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
    s_b_plain |=> CHAN_B_FOURTH_LANE[5:0] == ($past(layout_eff[1]) ? $past(b_lsb) : $past(b_msb)))
    else $error("channel B fourth lane carries wrong bits");

  a_narrow_b: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
    chan_on[1] && !l_cfg.rev[1] && !wide_eff[1] |=> CHAN_B_LANE0[5:0] == $past(l_rgb[1][23:18]))
    else $error("channel B 18 bpp reduction wrong");

  a_lane_off: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
    !wide_eff[1] |=> !($past(l_cfg.rev[1]) ? CHAN_B_LANE_EN[0] : CHAN_B_LANE_EN[3]))
    else $error("channel B fourth lane enabled in 18 bpp");

  a_single_off: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
    l_cfg.single |=> CHAN_B_LANE_EN == 5'h00 && !l_two_stream)
    else $error("channel B active in single link");

endmodule : lvdcfg_top

// ==== verif/lvdcfg_panel_model.sv ====
// Panel receiver model: captures one channel's lanes, undoing the board's pin reversal
`timescale 1ns/1ps

module lvdcfg_panel_model
  import lvdcfg_pkg::*;
(
  input  logic         link_clk,
  input  logic         board_rev,
  input  lvdcfg_word_t pin0,
  input  lvdcfg_word_t pin1,
  input  lvdcfg_word_t pin2,
  input  lvdcfg_word_t pin3,
  input  lvdcfg_word_t pinc,
  output lvdcfg_word_t rx0,
  output lvdcfg_word_t rx1,
  output lvdcfg_word_t rx2,
  output lvdcfg_word_t rx3,
  output lvdcfg_word_t rxc
);
  // Reversed board wiring swaps lane 0 with lane 3 and lane 1 with clock
  always_ff @(posedge link_clk) begin
    rx0 <= board_rev ? pin3 : pin0;
    rx1 <= board_rev ? pinc : pin1;
    rx2 <= pin2;
    rx3 <= board_rev ? pin0 : pin3;
    rxc <= board_rev ? pin1 : pinc;
  end
endmodule : lvdcfg_panel_model

// ==== verif/test_lvdcfg_top.sv ====
// Self-checking testbench of the LVDS lane configuration block
`timescale 1ns/1ps
`include "lvdcfg_defines.svh"

module test_lvdcfg_top
  import lvdcfg_pkg::*;
;
  logic CLK_SYS, RST_N, CYC_I, STB_I, WE_I, ACK_O, LINK_CLK, PIX_VALID, PIX_HS, PIX_VS, PIX_DE, board_rev;
  logic [`LVDCFG_ADR_W-1:0] ADR_I;
  logic [3:0] SEL_I;
  logic [31:0] DAT_I, DAT_O;
  lvdcfg_rgb_t PIX_A_RGB, PIX_B_RGB;
  lvdcfg_word_t CHAN_A_LANE0, CHAN_A_LANE1, CHAN_A_LANE2, CHAN_A_FOURTH_LANE, CHAN_A_CLK_LANE;
  lvdcfg_word_t CHAN_B_LANE0, CHAN_B_LANE1, CHAN_B_LANE2, CHAN_B_FOURTH_LANE, CHAN_B_CLK_LANE;
  lvdcfg_word_t rx0, rx1, rx2, rx3, rxc;
  logic [4:0] CHAN_A_LANE_EN, CHAN_B_LANE_EN;
  logic CHAN_A_TERMINATION_SELECT, CHAN_B_TERMINATION_SELECT, CHAN_A_COMMON_LEVEL_SELECT, CHAN_B_COMMON_LEVEL_SELECT;
  logic [1:0] CHAN_A_COMMON_LEVEL_TRIM, CHAN_B_COMMON_LEVEL_TRIM, CHAN_A_SWING_SELECT, CHAN_B_SWING_SELECT;
  logic [11:0] analog;
  logic [7:0] rd;
  int n_fail = 0;
  int n_checks = 0;
  localparam lvdcfg_rgb_t PA = 24'h8D4EB2;
  localparam lvdcfg_rgb_t PB = 24'h37C961;

  assign analog = {CHAN_A_TERMINATION_SELECT, CHAN_B_TERMINATION_SELECT, CHAN_A_COMMON_LEVEL_SELECT,
                   CHAN_B_COMMON_LEVEL_SELECT, CHAN_A_COMMON_LEVEL_TRIM, CHAN_B_COMMON_LEVEL_TRIM,
                   CHAN_A_SWING_SELECT, CHAN_B_SWING_SELECT};

  lvdcfg_top DUT (.CLK_SYS, .RST_N, .CYC_I, .STB_I, .WE_I, .ADR_I, .SEL_I, .DAT_I, .DAT_O, .ACK_O,
    .LINK_CLK, .PIX_VALID, .PIX_A_RGB, .PIX_B_RGB, .PIX_HS, .PIX_VS, .PIX_DE,
    .CHAN_A_LANE0, .CHAN_A_LANE1, .CHAN_A_LANE2, .CHAN_A_FOURTH_LANE, .CHAN_A_CLK_LANE, .CHAN_A_LANE_EN,
    .CHAN_B_LANE0, .CHAN_B_LANE1, .CHAN_B_LANE2, .CHAN_B_FOURTH_LANE, .CHAN_B_CLK_LANE, .CHAN_B_LANE_EN,
    .CHAN_A_TERMINATION_SELECT, .CHAN_B_TERMINATION_SELECT, .CHAN_A_COMMON_LEVEL_SELECT,
    .CHAN_B_COMMON_LEVEL_SELECT, .CHAN_A_COMMON_LEVEL_TRIM, .CHAN_B_COMMON_LEVEL_TRIM,
    .CHAN_A_SWING_SELECT, .CHAN_B_SWING_SELECT);

  lvdcfg_panel_model PANEL (.link_clk(LINK_CLK), .board_rev(board_rev), .pin0(CHAN_B_LANE0),
    .pin1(CHAN_B_LANE1), .pin2(CHAN_B_LANE2), .pin3(CHAN_B_FOURTH_LANE), .pinc(CHAN_B_CLK_LANE),
    .rx0(rx0), .rx1(rx1), .rx2(rx2), .rx3(rx3), .rxc(rxc));

  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end

  initial begin
    LINK_CLK = 1'b0;
    #7;
    forever #15 LINK_CLK = ~LINK_CLK;
  end

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      n_fail++;
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I  <= we;
    ADR_I <= {idx, 2'h0};
    DAT_I <= {24'h0, wd};
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (ACK_O !== 1'b1 && n < 100);
    if (n >= 100) chk("ack", 1, 0);
    rd = DAT_O[7:0];
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
  endtask : wb

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    chk("register", exp, rd);
  endtask : rdc

  // Status read stalls until the crossing is done, then the lane pipeline refills
  task automatic settle();
    wb(1'b0, `LVDCFG_IDX_STATUS, 8'h00);
    repeat (6) @(posedge LINK_CLK);
    @(posedge CLK_SYS);
  endtask : settle

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  initial begin
    #400us;
    n_fail++;
    test_done();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {RST_N, CYC_I, STB_I, WE_I, ADR_I, DAT_I, board_rev} = '0;
    SEL_I = 4'hF;
    {PIX_VALID, PIX_DE, PIX_VS, PIX_HS} = 4'hE;
    PIX_A_RGB = PA;
    PIX_B_RGB = PB;
    repeat (20) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    chk("analog", 12'hC05, analog);
    rdc(`LVDCFG_IDX_LEVEL, 8'h05);
    rdc(`LVDCFG_IDX_ROUTE, 8'h03);
    rdc(`LVDCFG_IDX_TRIM, 8'h00);
    rdc(`LVDCFG_IDX_LINK, 8'h10);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, `LVDCFG_IDX_TRIM, {2'h0, i[1:0], 2'h0, 2'(3 - i)});
      chk("trim", {i[1:0], 2'(3 - i)}, analog[7:4]);
    end
    wb(1'b1, `LVDCFG_IDX_TRIM, 8'h11);
    wb(1'b1, `LVDCFG_IDX_LEVEL, 8'h5A);
    wb(1'b1, `LVDCFG_IDX_ROUTE, 8'h00);
    chk("analog", 12'h35A, analog);
    rdc(`LVDCFG_IDX_LEVEL, 8'h5A);
    rdc(8'h3F, 8'h00);
    $display("test analog done");
    wb(1'b1, `LVDCFG_IDX_CHAN_MODE, 8'h40);
    wb(1'b1, `LVDCFG_IDX_LINK, 8'h0C);
    settle();
    chk("a lane0", {PA[8], PA[21:16]}, CHAN_A_LANE0);
    chk("a lane2", {3'h6, PA[5:2]}, CHAN_A_LANE2);
    chk("a clk", `LVDCFG_CLK_PATTERN, CHAN_A_CLK_LANE);
    chk("a enables", 5'h1F, CHAN_A_LANE_EN);
    chk("a fourth", {1'b0, PA[7:6], PA[15:14], PA[23:22]}, CHAN_A_FOURTH_LANE);
    chk("b fourth", {1'b0, PB[7:6], PB[15:14], PB[23:22]}, CHAN_B_FOURTH_LANE);
    wb(1'b1, `LVDCFG_IDX_LINK, 8'h0D);
    settle();
    chk("b fourth", {1'b0, PB[1:0], PB[9:8], PB[17:16]}, CHAN_B_FOURTH_LANE);
    wb(1'b1, `LVDCFG_IDX_LINK, 8'h09);
    settle();
    chk("b lane0", {PB[10], PB[23:18]}, CHAN_B_LANE0);
    chk("b fourth en", 0, CHAN_B_LANE_EN[3]);
    $display("test colour done");
    board_rev <= 1'b1;
    wb(1'b1, `LVDCFG_IDX_ROUTE, 8'h70);
    settle();
    chk("a lane1", `LVDCFG_CLK_PATTERN, CHAN_A_LANE1);
    chk("a fourth", {PB[8], PB[21:16]}, CHAN_A_FOURTH_LANE);
    chk("panel lane0", {PA[10], PA[23:18]}, rx0);
    chk("panel clk", `LVDCFG_CLK_PATTERN, rxc);
    chk("b lane2", {3'h6, PA[7:4]}, CHAN_B_LANE2);
    chk("b enables rev", 5'h1E, CHAN_B_LANE_EN);
    wb(1'b1, `LVDCFG_IDX_LINK, 8'h10);
    settle();
    chk("b enables", 0, CHAN_B_LANE_EN);
    $display("test routing done");
    test_done();
  end
endmodule : test_lvdcfg_top
